// [scg_defines.svh]
// Register indices, field positions, reset values and rate limits of the sample clock generator.
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH
`define SCG_IDX_RATE 16'd20000
`define SCG_IDX_PLL 16'd20030
`define SCG_IDX_CLKOUT 16'd20110
`define SCG_IDX_TERM 16'd20120
`define SCG_IDX_REF 16'd20140
`define SCG_IDX_CTRL 16'd20200
`define SCG_IDX_CFG 16'd20210
`define SCG_IDX_EXTDIV 16'd20220
`define SCG_IDX_STATUS 16'd20230
`define SCG_CTRL_RUN_BIT 0
`define SCG_CFG_EXTSEL_BIT 0
`define SCG_CFG_DUAL16_BIT 1
`define SCG_RST_RATE 32'h000f4240
`define SCG_RST_PLL 1'b1
`define SCG_RST_EXTDIV 16'h0001
`define SCG_CLK_HZ 32'd100000000
`define SCG_INT_REF_HZ 32'd40000000
`define SCG_MIN_RATE_HZ 32'd1000
`define SCG_MAX_SLOW_HZ 32'd10000000
`define SCG_MAX_SLOW16_HZ 32'd5000000
`define SCG_MAX_FAST_HZ 32'd40000000
`define SCG_REF_MIN_HZ 32'd1000000
`define SCG_REF_MAX_HZ 32'd125000000
`define SCG_NUM_DIVS 17
`endif

// [scg_pkg.sv]
// Types shared by the sample clock generator modules.
package scg_pkg;
  typedef enum logic [1:0] {
    SCG_SRC_PLL_INT = 2'b00,
    SCG_SRC_PLL_EXT = 2'b01,
    SCG_SRC_QUARTZ = 2'b10,
    SCG_SRC_EXT_DIV = 2'b11
  } scg_src_type;
  typedef enum logic {
    SCG_ST_IDLE = 1'b0,
    SCG_ST_RUN = 1'b1
  } scg_state_type;
endpackage

// [scg_phase_gen.sv]
// Phase accumulator that turns a rate in hertz into a clock level and a tick.
`timescale 1ns/1ps
`default_nettype none
module scg_phase_gen
  import scg_pkg::*;
#(
  parameter logic [31:0] CLK_HZ = 32'd100000000
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control.
  input wire logic en_i,
  input wire logic [31:0] rate_i,
  // Generated clock.
  output logic level_o,
  output logic tick_o
);
  logic [32:0] acc_q;
  logic [32:0] sum;
  logic wrap;

  // Two steps per period, so the level toggles at twice the rate.
  assign sum = acc_q + {rate_i, 1'b0};
  assign wrap = sum >= {1'b0, CLK_HZ};

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      acc_q <= 33'h000000000;
      level_o <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      acc_q <= wrap ? sum - {1'b0, CLK_HZ} : sum;
      level_o <= level_o ^ wrap;
      tick_o <= wrap && !level_o;
    end
  end
endmodule
`default_nettype wire

// [scg_top.sv]
// Sample clock generator: register file, source selection and sample tick generation.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.svh"
// Function
// - Default source is PLL from 40 MHz
// - Rate read returns nearest achievable rate
// - Clock output only with internal clocking
// - Never below 1 kHz
// - Maximum rate by variant and channels
// - PLL enable one, zero selects quartz
// - Bypass uses fixed divider set, best match
// - Quartz runs at variant maximum rate
// - Reference zero internal, else 1-125 MHz
// - External reference feeds PLL from connector
// - Termination only while connector is input
// - External clock may be divided down
module scg_top
  import scg_pkg::*;
#(
  parameter bit FAST_VARIANT = 1'b0
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // External clock connector.
  input wire logic conn_i,
  output logic conn_o,
  output logic conn_oe_n_o,
  output logic term_en_o,
  // Clock synthesiser control.
  output logic pll_ref_ext_o,
  output logic pll_bypass_o,
  output logic [31:0] pll_rate_hz_o,
  output logic [31:0] pll_ref_hz_o,
  output logic [10:0] quartz_div_o,
  // Sample clock.
  output logic sample_tick_o,
  output logic running_o
);
  localparam logic [31:0] MAX_HZ = FAST_VARIANT ? `SCG_MAX_FAST_HZ : `SCG_MAX_SLOW_HZ;
  localparam logic [31:0] QUARTZ_HZ = MAX_HZ;
  localparam int NDIV = `SCG_NUM_DIVS;
  localparam logic [10:0] DIVS [NDIV] = '{11'd1, 11'd2, 11'd4, 11'd8, 11'd10, 11'd16,
    11'd20, 11'd40, 11'd50, 11'd80, 11'd100, 11'd200, 11'd400, 11'd500, 11'd800,
    11'd1000, 11'd2000};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Software registers.
  logic [31:0] rate_q, ref_q;
  logic pll_q, clkout_q, term_q, extsel_q, dual16_q;
  logic [15:0] extdiv_q;
  scg_state_type state_q;
  // Configuration in use while running.
  scg_src_type act_src_q;
  logic [31:0] act_rate_q, act_ref_q;
  logic [10:0] act_div_q;
  logic [15:0] act_extdiv_q;
  logic act_clkout_q;

  // Bus decode.
  logic req, wr, rd;
  logic [15:0] idx;
  logic hit_rate, hit_pll, hit_clkout, hit_term, hit_ref, hit_ctrl, hit_cfg, hit_ext, hit_st;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign idx = (wb_adr_i[31:18] == 14'h0000 && wb_adr_i[1:0] == 2'h0) ? wb_adr_i[17:2] : 16'hffff;
  assign hit_rate = idx == `SCG_IDX_RATE;
  assign hit_pll = idx == `SCG_IDX_PLL;
  assign hit_clkout = idx == `SCG_IDX_CLKOUT;
  assign hit_term = idx == `SCG_IDX_TERM;
  assign hit_ref = idx == `SCG_IDX_REF;
  assign hit_ctrl = idx == `SCG_IDX_CTRL;
  assign hit_cfg = idx == `SCG_IDX_CFG;
  assign hit_ext = idx == `SCG_IDX_EXTDIV;
  assign hit_st = idx == `SCG_IDX_STATUS;

  // Rate limits and the nearest achievable rate.
  logic [31:0] max_rate, clamped, best_q_rate, best_rate;
  logic [10:0] best_div;
  logic [31:0] rate_tab [NDIV];
  assign max_rate = (!FAST_VARIANT && dual16_q) ? `SCG_MAX_SLOW16_HZ : MAX_HZ;
  assign clamped = (rate_q < `SCG_MIN_RATE_HZ) ? `SCG_MIN_RATE_HZ :
                   (rate_q > max_rate) ? max_rate : rate_q;
  for (genvar g = 0; g < NDIV; g++) begin : g_tab
    assign rate_tab[g] = QUARTZ_HZ / {21'h000000, DIVS[g]};
  end

  // Quartz mode can only hit quartz over one of the fixed dividers.
  always_comb begin
    logic [31:0] diff, bdiff;
    diff = 32'h00000000;
    bdiff = 32'hffffffff;
    best_q_rate = `SCG_MIN_RATE_HZ;
    best_div = DIVS[NDIV-1];
    for (int k = 0; k < NDIV; k++) begin
      diff = (rate_tab[k] > rate_q) ? rate_tab[k] - rate_q : rate_q - rate_tab[k];
      if (rate_tab[k] <= max_rate && rate_tab[k] >= `SCG_MIN_RATE_HZ && diff < bdiff) begin
        bdiff = diff;
        best_q_rate = rate_tab[k];
        best_div = DIVS[k];
      end
    end
  end
  assign best_rate = pll_q ? clamped : best_q_rate;

  // Source selection from the programmed registers.
  scg_src_type src_sel;
  assign src_sel = extsel_q ? SCG_SRC_EXT_DIV :
                   !pll_q ? SCG_SRC_QUARTZ :
                   (ref_q != 32'h00000000) ? SCG_SRC_PLL_EXT : SCG_SRC_PLL_INT;

  logic [31:0] ref_new, ext_new;
  logic ref_ok, start, stop;
  assign ref_new = merge(ref_q, wb_dat_i, wb_sel_i);
  // Only the low two lanes reach the 16-bit divider.
  assign ext_new = merge({16'h0000, extdiv_q}, wb_dat_i, wb_sel_i & 4'h3);
  // Out of range reference values are dropped rather than clamped.
  assign ref_ok = ref_new == 32'h00000000 ||
                  (ref_new >= `SCG_REF_MIN_HZ && ref_new <= `SCG_REF_MAX_HZ);
  assign start = wr && hit_ctrl && wb_sel_i[0] && wb_dat_i[`SCG_CTRL_RUN_BIT];
  assign stop = wr && hit_ctrl && wb_sel_i[0] && !wb_dat_i[`SCG_CTRL_RUN_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_q <= `SCG_RST_RATE;
      ref_q <= 32'h00000000;
      pll_q <= `SCG_RST_PLL;
      clkout_q <= 1'b0;
      term_q <= 1'b0;
      extsel_q <= 1'b0;
      dual16_q <= 1'b0;
      extdiv_q <= `SCG_RST_EXTDIV;
    end else if (wr) begin
      if (hit_rate) rate_q <= merge(rate_q, wb_dat_i, wb_sel_i);
      if (hit_ref && ref_ok) ref_q <= ref_new;
      if (hit_pll && wb_sel_i[0]) pll_q <= wb_dat_i[0];
      if (hit_clkout && wb_sel_i[0]) clkout_q <= wb_dat_i[0];
      if (hit_term && wb_sel_i[0]) term_q <= wb_dat_i[0];
      if (hit_cfg && wb_sel_i[0]) extsel_q <= wb_dat_i[`SCG_CFG_EXTSEL_BIT];
      if (hit_cfg && wb_sel_i[0]) dual16_q <= wb_dat_i[`SCG_CFG_DUAL16_BIT];
      if (hit_ext && ext_new[15:0] != 16'h0000) extdiv_q <= ext_new[15:0];
    end
  end

  // Run control; the working set is frozen while running.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SCG_ST_IDLE;
      act_src_q <= SCG_SRC_PLL_INT;
      act_rate_q <= `SCG_RST_RATE;
      act_ref_q <= 32'h00000000;
      act_div_q <= 11'd1;
      act_extdiv_q <= `SCG_RST_EXTDIV;
      act_clkout_q <= 1'b0;
    end else begin
      case (state_q)
        SCG_ST_IDLE: begin
          if (start) begin
            state_q <= SCG_ST_RUN;
            act_src_q <= src_sel;
            act_rate_q <= best_rate;
            act_ref_q <= ref_q == 32'h00000000 ? `SCG_INT_REF_HZ : ref_q;
            act_div_q <= best_div;
            act_extdiv_q <= extdiv_q;
            act_clkout_q <= clkout_q;
          end
        end
        SCG_ST_RUN: begin
          if (stop) state_q <= SCG_ST_IDLE;
        end
        default: state_q <= SCG_ST_IDLE;
      endcase
    end
  end

  // Connector input passes three flops; a rising edge counts once the last two agree.
  logic [2:0] sync_q;
  logic conn_lvl_q, ext_edge, ext_tick;
  logic [15:0] ext_cnt_q;
  assign ext_edge = sync_q[1] == sync_q[2] && sync_q[2] && !conn_lvl_q;
  assign ext_tick = ext_edge && ext_cnt_q == act_extdiv_q - 16'h0001;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_q <= 3'h0;
      conn_lvl_q <= 1'b0;
      ext_cnt_q <= 16'h0000;
    end else begin
      sync_q <= {sync_q[1:0], conn_i};
      if (sync_q[1] == sync_q[2]) conn_lvl_q <= sync_q[2];
      if (state_q == SCG_ST_IDLE || ext_tick) ext_cnt_q <= 16'h0000;
      else if (ext_edge) ext_cnt_q <= ext_cnt_q + 16'h0001;
    end
  end

  logic run, internal, pg_level, pg_tick;
  assign run = state_q == SCG_ST_RUN;
  assign internal = act_src_q == SCG_SRC_PLL_INT || act_src_q == SCG_SRC_QUARTZ;
  scg_phase_gen #(.CLK_HZ(`SCG_CLK_HZ)) u_phase (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(run && act_src_q != SCG_SRC_EXT_DIV),
    .rate_i(act_rate_q),
    .level_o(pg_level),
    .tick_o(pg_tick)
  );

  // Pin and synthesiser outputs.
  logic drive;
  assign drive = run && act_clkout_q && internal;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conn_o <= 1'b0;
      conn_oe_n_o <= 1'b1;
      term_en_o <= 1'b0;
      pll_ref_ext_o <= 1'b0;
      pll_bypass_o <= 1'b0;
      pll_rate_hz_o <= `SCG_RST_RATE;
      pll_ref_hz_o <= `SCG_INT_REF_HZ;
      quartz_div_o <= 11'd1;
      sample_tick_o <= 1'b0;
      running_o <= 1'b0;
    end else begin
      conn_o <= drive && pg_level;
      conn_oe_n_o <= !drive;
      term_en_o <= term_q && !drive;
      pll_ref_ext_o <= act_src_q == SCG_SRC_PLL_EXT;
      pll_bypass_o <= act_src_q == SCG_SRC_QUARTZ;
      pll_rate_hz_o <= act_rate_q;
      pll_ref_hz_o <= act_ref_q;
      quartz_div_o <= act_div_q;
      sample_tick_o <= run && (act_src_q == SCG_SRC_EXT_DIV ? ext_tick : pg_tick);
      running_o <= run;
    end
  end

  // Bus answer one cycle after the request.
  logic [31:0] rd_mux;
  assign rd_mux = hit_rate ? best_rate :
                  hit_pll ? {31'h0, pll_q} :
                  hit_clkout ? {31'h0, clkout_q} :
                  hit_term ? {31'h0, term_q} :
                  hit_ref ? ref_q :
                  hit_ctrl ? {31'h0, run} :
                  hit_cfg ? {30'h0, dual16_q, extsel_q} :
                  hit_ext ? {16'h0, extdiv_q} :
                  hit_st ? {29'h0, act_src_q, run} : 32'h00000000;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rd_mux : 32'h00000000;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_idle_start;
    state_q == SCG_ST_IDLE && start;
  endsequence
  sequence s_rate_read;
    rd && hit_rate;
  endsequence

  a_rate_floor: assert property (best_rate >= `SCG_MIN_RATE_HZ)
    else $error("rate below floor");
  a_rate_cap: assert property (best_rate <= max_rate)
    else $error("rate above variant maximum");
  a_rate_readback: assert property (s_rate_read |=>
    wb_ack_o && wb_dat_o == $past(best_rate))
    else $error("rate readback wrong");
  a_start_applies: assert property (s_idle_start |=>
    run && act_rate_q == $past(best_rate))
    else $error("start did not apply settings");
  a_run_frozen: assert property (run && $past(run) |->
    $stable(act_rate_q) && $stable(act_src_q))
    else $error("settings changed while running");
  a_bypass_div: assert property (!pll_q |-> best_rate * {21'h0, best_div} == QUARTZ_HZ)
    else $error("bypass rate not quartz over divider");
  a_clkout_int: assert property (!conn_oe_n_o |->
    $past(internal) && $past(act_clkout_q))
    else $error("clock driven without internal clocking");
  a_term_input: assert property (term_en_o |-> conn_oe_n_o)
    else $error("termination while driving");
  a_ref_range: assert property (ref_q == 0 ||
    (ref_q >= `SCG_REF_MIN_HZ && ref_q <= `SCG_REF_MAX_HZ))
    else $error("reference out of range");
  a_ref_route: assert property (run && act_src_q == SCG_SRC_PLL_EXT |=>
    pll_ref_ext_o ##0 !pll_bypass_o)
    else $error("external reference not routed");
  a_ack_pulse: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");
endmodule
`default_nettype wire

// [scg_ext_source.sv]
// Behavioural external clock source on the far side of the connector.
`timescale 1ns/1ps
`default_nettype none
module scg_ext_source #(
  parameter int HALF_NS = 250
) (
  // Control.
  input wire logic en_i,
  // Clock to the connector.
  output logic clk_o
);
  // The source stands low while en_i is low, so no stray edge reaches the counter.
  initial begin
    clk_o = 1'b0;
    forever begin
      #(HALF_NS);
      clk_o = en_i ? ~clk_o : 1'b0;
    end
  end
endmodule
`default_nettype wire

// [test_sample_clock_generator.sv]
// Self-checking bench for the sample clock generator.
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.svh"
module test_sample_clock_generator;
  import scg_pkg::*;
  typedef struct {
    logic [15:0] widx;
    logic [31:0] wdat;
    logic [15:0] ridx;
    logic [31:0] exp;
  } scg_row_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, pll_rate_hz_o, pll_ref_hz_o, rd;
  logic [31:0] wb_dat_o_fast, rd_fast;
  logic wb_ack_o, conn_o, conn_oe_n_o, term_en_o, pll_ref_ext_o, pll_bypass_o;
  logic [10:0] quartz_div_o;
  logic sample_tick_o, running_o, src_clk, conn_w;
  logic src_en = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  int ticks;
  int hi_cnt;
  // Slow variant: top rate and quartz are both 10 MHz.
  scg_row_type rows [19] = '{
    '{16'h0, 32'h0, `SCG_IDX_RATE, 32'h000f4240},
    '{16'h0, 32'h0, `SCG_IDX_PLL, 32'h1},
    '{16'h0, 32'h0, `SCG_IDX_CLKOUT, 32'h0},
    '{16'h0, 32'h0, `SCG_IDX_TERM, 32'h0},
    '{16'h0, 32'h0, `SCG_IDX_REF, 32'h0},
    '{`SCG_IDX_RATE, 32'h1f4, `SCG_IDX_RATE, 32'h3e8},
    '{`SCG_IDX_RATE, 32'h01312d00, `SCG_IDX_RATE, 32'h00989680},
    '{`SCG_IDX_CFG, 32'h2, `SCG_IDX_RATE, 32'h004c4b40},
    '{`SCG_IDX_CFG, 32'h0, `SCG_IDX_RATE, 32'h00989680},
    '{`SCG_IDX_RATE, 32'h0012d687, `SCG_IDX_RATE, 32'h0012d687},
    '{`SCG_IDX_PLL, 32'h0, `SCG_IDX_RATE, 32'h001312d0},
    '{`SCG_IDX_RATE, 32'h002dc6c0, `SCG_IDX_RATE, 32'h002625a0},
    '{`SCG_IDX_RATE, 32'h3e8, `SCG_IDX_RATE, 32'h1388},
    '{`SCG_IDX_PLL, 32'h1, `SCG_IDX_PLL, 32'h1},
    '{`SCG_IDX_REF, 32'h0007a120, `SCG_IDX_REF, 32'h0},
    '{`SCG_IDX_REF, 32'h07735941, `SCG_IDX_REF, 32'h0},
    '{`SCG_IDX_REF, 32'h07735940, `SCG_IDX_REF, 32'h07735940},
    '{`SCG_IDX_REF, 32'h0, `SCG_IDX_REF, 32'h0},
    '{16'h0, 32'h0, 16'h0001, 32'h0}
  };
  // The connector carries the design's clock while it drives, else the source's.
  assign conn_w = (conn_oe_n_o === 1'b0) ? conn_o : src_clk;
  always #5 clk_i = ~clk_i;
  scg_top #(.FAST_VARIANT(1'b0)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conn_i(conn_w), .conn_o(conn_o),
    .conn_oe_n_o(conn_oe_n_o), .term_en_o(term_en_o), .pll_ref_ext_o(pll_ref_ext_o),
    .pll_bypass_o(pll_bypass_o), .pll_rate_hz_o(pll_rate_hz_o),
    .pll_ref_hz_o(pll_ref_hz_o), .quartz_div_o(quartz_div_o),
    .sample_tick_o(sample_tick_o), .running_o(running_o)
  );
  scg_ext_source #(.HALF_NS(250)) u_src (.en_i(src_en), .clk_o(src_clk));
  // A fast variant on the same bus; only its read data is looked at.
  scg_top #(.FAST_VARIANT(1'b1)) u_fast (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o_fast), .wb_ack_o(), .conn_i(src_clk), .conn_o(), .conn_oe_n_o(),
    .term_en_o(), .pll_ref_ext_o(), .pll_bypass_o(), .pll_rate_hz_o(), .pll_ref_hz_o(),
    .quartz_div_o(), .sample_tick_o(), .running_o()
  );
  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // The request stands until ack is sampled high or 20 cycles pass; only then is it released.
  task automatic bus(input logic we, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {14'h0, idx, 2'b00};
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    rd_fast = wb_dat_o_fast;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) err_total++;
  endtask
  task automatic run(input logic on);
    bus(1'b1, `SCG_IDX_CTRL, {31'h0, on});
    repeat (3) @(posedge clk_i);
  endtask
  task automatic count_ticks(input int cycles);
    ticks = 0;
    hi_cnt = 0;
    repeat (cycles) begin
      @(posedge clk_i);
      if (sample_tick_o === 1'b1) ticks++;
      if (conn_o === 1'b1) hi_cnt++;
    end
  endtask
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("ref_hz", 32'h02625a00, pll_ref_hz_o);
    chk("bypass", 32'h0, {31'h0, pll_bypass_o});
    chk("running", 32'h0, {31'h0, running_o});
    chk("oe_n", 32'h1, {31'h0, conn_oe_n_o});
    foreach (rows[i]) begin
      if (rows[i].widx != 16'h0) bus(1'b1, rows[i].widx, rows[i].wdat);
      bus(1'b0, rows[i].ridx, 32'h0);
      chk("readback", rows[i].exp, rd);
    end
    // Both variants share the bus; the fast one ignores the channel setup.
    bus(1'b1, `SCG_IDX_RATE, 32'h02faf080);
    bus(1'b1, `SCG_IDX_CFG, 32'h2);
    bus(1'b0, `SCG_IDX_RATE, 32'h0);
    chk("rate_slow16", 32'h004c4b40, rd);
    chk("rate_fast", 32'h02625a00, rd_fast);
    bus(1'b1, `SCG_IDX_CFG, 32'h0);
    bus(1'b1, `SCG_IDX_RATE, 32'h00989680);
    bus(1'b1, `SCG_IDX_CLKOUT, 32'h1);
    bus(1'b1, `SCG_IDX_TERM, 32'h1);
    run(1'b1);
    chk("running", 32'h1, {31'h0, running_o});
    chk("oe_n", 32'h0, {31'h0, conn_oe_n_o});
    chk("term", 32'h0, {31'h0, term_en_o});
    bus(1'b1, `SCG_IDX_RATE, 32'h004c4b40);
    count_ticks(1000);
    chk("pll_ticks", 32'h1, {31'h0, ticks >= 99 && ticks <= 101});
    chk("conn_high", 32'h1, {31'h0, hi_cnt >= 495 && hi_cnt <= 505});
    chk("rate_hold", 32'h00989680, pll_rate_hz_o);
    run(1'b0);
    chk("running", 32'h0, {31'h0, running_o});
    run(1'b1);
    chk("rate_new", 32'h004c4b40, pll_rate_hz_o);
    run(1'b0);
    // Programmed reference equals what the source really delivers.
    bus(1'b1, `SCG_IDX_REF, 32'h001e8480);
    src_en <= 1'b1;
    run(1'b1);
    chk("ref_ext", 32'h1, {31'h0, pll_ref_ext_o});
    chk("ref_hz", 32'h001e8480, pll_ref_hz_o);
    chk("oe_n", 32'h1, {31'h0, conn_oe_n_o});
    chk("term", 32'h1, {31'h0, term_en_o});
    bus(1'b0, `SCG_IDX_STATUS, 32'h0);
    chk("status", 32'h3, rd);
    run(1'b0);
    bus(1'b1, `SCG_IDX_PLL, 32'h0);
    bus(1'b1, `SCG_IDX_RATE, 32'h002dc6c0);
    run(1'b1);
    chk("bypass", 32'h1, {31'h0, pll_bypass_o});
    chk("div", 32'h4, {21'h0, quartz_div_o});
    count_ticks(1000);
    chk("quartz_ticks", 32'h1, {31'h0, ticks >= 24 && ticks <= 26});
    run(1'b0);
    bus(1'b1, `SCG_IDX_EXTDIV, 32'h4);
    bus(1'b1, `SCG_IDX_CFG, 32'h1);
    run(1'b1);
    chk("oe_n", 32'h1, {31'h0, conn_oe_n_o});
    count_ticks(4000);
    chk("ext_ticks", 32'h1, {31'h0, ticks >= 19 && ticks <= 21});
    chk("conn_quiet", 32'h0, hi_cnt);
    // Reset in mid-run must drop the run and restore every setting.
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("running", 32'h0, {31'h0, running_o});
    chk("ref_ext", 32'h0, {31'h0, pll_ref_ext_o});
    chk("rate_hz", 32'h000f4240, pll_rate_hz_o);
    chk("ref_hz", 32'h02625a00, pll_ref_hz_o);
    bus(1'b0, `SCG_IDX_PLL, 32'h0);
    chk("pll_rst", 32'h1, rd);
    bus(1'b0, `SCG_IDX_CFG, 32'h0);
    chk("cfg_rst", 32'h0, rd);
    src_en <= 1'b0;
    wrap_up();
  end
endmodule
`default_nettype wire
